// >>> rtl/apc_defines.svh
// register map, field positions, reset values and divider counts of the analog power control
// Overview of operation
// R01: supply tap enable set connects the analog supply to the tap output; clear disconnects.
// R02: input select 00 half supply, 01 third, 10 external input, 11 floating.
// R03: result one means supply above 2.3 V (select 00) or 3.5 V (select 01).
// R04: battery status bit 0 reads one when the selected voltage exceeds 1.2 V.
// R05: battery status is read-only; writes have no effect.
// R06: comparator enable bit 1 of supply-monitor control switches the comparator on or off.
// R07: bandgap enable bit 6 turns bandgap reference and temperature sensor on together.
// R08: regulator enable bit 5 turns the analog supply regulator on; clear leaves it off.
// R09: common-voltage enable bit 1 holds analog common at half supply; clear floats it.
// R10: bias enable bit 0 powers bias supply; without it analog functions are not operable.
// R11: doubler clock is main/200, main/100 by rate select, or external/32 by source bit.
// R12: software enables doubler, regulator, bias, then common voltage, comparator or bandgap.
// R13: all implemented control bits reset to zero, every analog function disabled.
// R14: unimplemented control bits ignore writes and read back as zero.
// R15: doubler enable bit 6 of pump clock control starts or stops the doubler.
// R16: every enable and select is a stable level, updated on the completing write edge.
// R17: comparator result passes a synchroniser before it is read.
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

`define APC_IDX_CLOCK_SELECT 6'h14
`define APC_IDX_PUMP_CLOCK 6'h15
`define APC_IDX_SUPPLY_MON 6'h1c
`define APC_IDX_ANALOG_EN 6'h1d
`define APC_IDX_BATT_STATUS 6'h1f
`define APC_IDX_IRQ_STATUS 6'h20
`define APC_IDX_IRQ_CLEAR 6'h21
`define APC_IDX_IRQ_ENABLE 6'h22

`define APC_REG_RESET 8'h00
`define APC_MASK_CLOCK_SELECT 8'hef
`define APC_MASK_PUMP_CLOCK 8'h4f
`define APC_MASK_SUPPLY_MON 8'h1e
`define APC_MASK_ANALOG_EN 8'h63
`define APC_MASK_BATT_STATUS 8'h01
`define APC_MASK_IRQ 8'h03

`define APC_CKS_SRC_BIT 0
`define APC_PCK_DOUBLER_BIT 6
`define APC_PCK_RATE_BIT 0
`define APC_SMC_TAP_BIT 4
`define APC_SMC_SEL_HI 3
`define APC_SMC_SEL_LO 2
`define APC_SMC_CMP_BIT 1
`define APC_AEN_BANDGAP_BIT 6
`define APC_AEN_REG_BIT 5
`define APC_AEN_COMMON_BIT 1
`define APC_AEN_BIAS_BIT 0
`define APC_BAT_RESULT_BIT 0
`define APC_IRQ_RISE_BIT 0
`define APC_IRQ_FALL_BIT 1

`define APC_SYNC_LOWBAT 0
`define APC_SYNC_MAIN 1
`define APC_SYNC_EXT 2

`define APC_HALF_MAIN_SLOW 7'd100
`define APC_HALF_MAIN_FAST 7'd50
`define APC_HALF_EXT 7'd16

`endif

// >>> rtl/apc_div_if.sv
// carrier between register bank and doubler clock divider
`timescale 1ns/1ps
interface apc_div_if;
    logic main_lvl;
    logic ext_lvl;
    logic src_sel;
    logic rate_sel;
    logic run;
    logic pump_clk;

    modport ctl (output main_lvl, output ext_lvl, output src_sel, output rate_sel,
        output run, input pump_clk);
    modport div (input main_lvl, input ext_lvl, input src_sel, input rate_sel,
        input run, output pump_clk);
endinterface : apc_div_if

// >>> rtl/apc_pkg.sv
// types shared by the analog power control modules
package apc_pkg;

    typedef enum logic [1:0] {
        APC_LB_HALF = 2'b00,
        APC_LB_THIRD = 2'b01,
        APC_LB_EXT = 2'b10,
        APC_LB_FLOAT = 2'b11
    } apc_lb_sel_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic [7:0] cks;
        logic [7:0] pump_clock_ctrl;
        logic [7:0] smc;
        logic [7:0] aen;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] stable;
        logic lb_prev;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic above_low;
        logic above_high;
    } apc_regs_state_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic pump_clk;
        logic main_prev;
        logic ext_prev;
    } apc_div_state_t;

endpackage : apc_pkg

// >>> rtl/apc_power_regs.sv
// analog power control register bank with wishbone slave and interrupt
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "apc_defines.svh"
module apc_power_regs
    import apc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_wdata,
    output logic [31:0] wb_rdata,
    output logic wb_ack,
    input wire logic main_clock,
    input wire logic external_osc_clock,
    input wire logic lowbat_result_async,
    output logic [7:0] clock_select_out,
    output logic main_clk_src_sel,
    output logic doubler_en,
    output logic doubler_rate_sel,
    output logic doubler_clk,
    output logic regulator_en,
    output logic supply_tap_en,
    output logic bias_en,
    output logic common_voltage_en,
    output logic bandgap_en,
    output logic lowbat_cmp_en,
    output logic [1:0] lowbat_input_sel,
    output logic lowbat_route_half,
    output logic lowbat_route_third,
    output logic lowbat_route_ext,
    output logic supply_above_2v3,
    output logic supply_above_3v5,
    output logic analog_ready,
    output logic irq
);

    apc_regs_state_t q;
    apc_regs_state_t d;

    apc_div_if div_link();

    logic req;
    logic wr_now;
    logic [5:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rd_value;
    logic [2:0] route;
    logic lb_valid;
    logic lb_now;
    logic [1:0] irq_events;
    logic [1:0] irq_clear;

    // one-hot comparator input route: half, third, external; floating drives none
    function automatic logic [2:0] lb_route(input logic [1:0] sel);
        logic [2:0] r;
        r = 3'b000;
        unique case (apc_lb_sel_t'(sel))
            APC_LB_HALF: begin
                r = 3'b001; // R02
            end
            APC_LB_THIRD: begin
                r = 3'b010; // R02
            end
            APC_LB_EXT: begin
                r = 3'b100; // R02
            end
            APC_LB_FLOAT: begin
                r = 3'b000; // R02
            end
        endcase
        return r;
    endfunction : lb_route

    // merge a write into a register, keeping unimplemented bits at zero
    function automatic logic [7:0] masked_write(input logic [7:0] data, input logic [7:0] mask);
        return data & mask;
    endfunction : masked_write

    always_comb begin
        d = q;
        req = wb_cyc & wb_stb;
        idx = wb_adr[7:2];
        wbyte = wb_wdata[7:0];
        // writes land on the edge where the master samples ack, not before
        wr_now = req & wb_we & q.ack & wb_sel[0];
        irq_clear = 2'b00;

        // three-stage synchronisers; a change counts when stages two and three agree
        d.s1 = {external_osc_clock, main_clock, lowbat_result_async};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 3; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.stable[i] = q.s3[i]; // R17
            end
        end

        // comparator result is only meaningful with bias up and the comparator on
        route = lb_route(q.smc[`APC_SMC_SEL_HI:`APC_SMC_SEL_LO]);
        lb_valid = q.smc[`APC_SMC_CMP_BIT] & q.aen[`APC_AEN_BIAS_BIT] & (|route); // R06 R10
        lb_now = q.stable[`APC_SYNC_LOWBAT] & lb_valid; // R04
        d.lb_prev = lb_now;
        d.above_low = lb_now & route[0]; // R03
        d.above_high = lb_now & route[1]; // R03

        irq_events = 2'b00;
        irq_events[`APC_IRQ_RISE_BIT] = lb_now & ~q.lb_prev;
        irq_events[`APC_IRQ_FALL_BIT] = ~lb_now & q.lb_prev;

        // bus answer: ack one cycle after the request, dropped the cycle after
        d.ack = req & ~q.ack;

        rd_value = 8'h00;
        unique case (idx)
            `APC_IDX_CLOCK_SELECT: begin
                rd_value = q.cks & `APC_MASK_CLOCK_SELECT; // R14
            end
            `APC_IDX_PUMP_CLOCK: begin
                rd_value = q.pump_clock_ctrl & `APC_MASK_PUMP_CLOCK; // R14
            end
            `APC_IDX_SUPPLY_MON: begin
                rd_value = q.smc & `APC_MASK_SUPPLY_MON; // R14
            end
            `APC_IDX_ANALOG_EN: begin
                rd_value = q.aen & `APC_MASK_ANALOG_EN; // R14
            end
            `APC_IDX_BATT_STATUS: begin
                rd_value[`APC_BAT_RESULT_BIT] = lb_now; // R04
            end
            `APC_IDX_IRQ_STATUS: begin
                rd_value = {6'h00, q.irq_stat};
            end
            `APC_IDX_IRQ_ENABLE: begin
                rd_value = {6'h00, q.irq_en};
            end
            default: begin
                // unmapped and write-only addresses read as zero and still ack
                rd_value = 8'h00;
            end
        endcase
        if (req & ~q.ack) begin
            d.rdata = rd_value;
        end

        if (wr_now) begin
            unique case (idx)
                `APC_IDX_CLOCK_SELECT: begin
                    d.cks = masked_write(wbyte, `APC_MASK_CLOCK_SELECT); // R16
                end
                `APC_IDX_PUMP_CLOCK: begin
                    d.pump_clock_ctrl = masked_write(wbyte, `APC_MASK_PUMP_CLOCK); // R16
                end
                `APC_IDX_SUPPLY_MON: begin
                    d.smc = masked_write(wbyte, `APC_MASK_SUPPLY_MON); // R14
                end
                `APC_IDX_ANALOG_EN: begin
                    d.aen = masked_write(wbyte, `APC_MASK_ANALOG_EN); // R14
                end
                `APC_IDX_BATT_STATUS: begin
                    d.aen = q.aen; // R05
                end
                `APC_IDX_IRQ_CLEAR: begin
                    irq_clear = wbyte[1:0];
                end
                `APC_IDX_IRQ_ENABLE: begin
                    d.irq_en = wbyte[1:0];
                end
                default: begin
                    d.irq_en = q.irq_en;
                end
            endcase
        end

        // a new event in the clearing cycle survives the clear
        d.irq_stat = (q.irq_stat & ~irq_clear) | irq_events;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0; // R13
        end else begin
            q <= d;
        end
    end

    // divider takes synchronised clock levels and the rate controls
    assign div_link.main_lvl = q.stable[`APC_SYNC_MAIN];
    assign div_link.ext_lvl = q.stable[`APC_SYNC_EXT];
    assign div_link.src_sel = q.cks[`APC_CKS_SRC_BIT]; // R11
    assign div_link.rate_sel = q.pump_clock_ctrl[`APC_PCK_RATE_BIT]; // R11
    assign div_link.run = q.pump_clock_ctrl[`APC_PCK_DOUBLER_BIT]; // R15

    apc_pump_div u_pump_div (
        .clk(clk),
        .resetn(resetn),
        .dv(div_link.div)
    );

    assign wb_rdata = {24'h000000, q.rdata};
    assign wb_ack = q.ack;

    assign clock_select_out = q.cks;
    assign main_clk_src_sel = q.cks[`APC_CKS_SRC_BIT];
    assign doubler_en = q.pump_clock_ctrl[`APC_PCK_DOUBLER_BIT]; // R15
    assign doubler_rate_sel = q.pump_clock_ctrl[`APC_PCK_RATE_BIT];
    assign doubler_clk = div_link.pump_clk; // R11
    assign regulator_en = q.aen[`APC_AEN_REG_BIT]; // R08
    assign supply_tap_en = q.smc[`APC_SMC_TAP_BIT]; // R01
    assign bias_en = q.aen[`APC_AEN_BIAS_BIT]; // R10
    assign common_voltage_en = q.aen[`APC_AEN_COMMON_BIT]; // R09
    assign bandgap_en = q.aen[`APC_AEN_BANDGAP_BIT]; // R07
    assign lowbat_cmp_en = q.smc[`APC_SMC_CMP_BIT]; // R06
    assign lowbat_input_sel = q.smc[`APC_SMC_SEL_HI:`APC_SMC_SEL_LO]; // R02
    assign lowbat_route_half = route[0];
    assign lowbat_route_third = route[1];
    assign lowbat_route_ext = route[2];
    assign supply_above_2v3 = q.above_low;
    assign supply_above_3v5 = q.above_high;
    // not a sequencing check: regulator plus bias is the least for analog use
    assign analog_ready = q.aen[`APC_AEN_REG_BIT] & q.aen[`APC_AEN_BIAS_BIT]; // R10
    assign irq = |(q.irq_stat & q.irq_en);

endmodule : apc_power_regs

// >>> rtl/apc_pump_div.sv
// doubler switching clock divider
`timescale 1ns/1ps
`include "apc_defines.svh"
module apc_pump_div
    import apc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    apc_div_if.div dv
);

    apc_div_state_t q;
    apc_div_state_t d;
    logic edge_seen;
    logic [6:0] half;

    always_comb begin
        d = q;
        d.main_prev = dv.main_lvl;
        d.ext_prev = dv.ext_lvl;
        edge_seen = dv.src_sel ? (dv.ext_lvl & ~q.ext_prev) : (dv.main_lvl & ~q.main_prev);
        if (dv.src_sel) begin
            half = `APC_HALF_EXT; // R11
        end else if (dv.rate_sel) begin
            half = `APC_HALF_MAIN_FAST; // R11
        end else begin
            half = `APC_HALF_MAIN_SLOW; // R11
        end
        if (!dv.run) begin
            d.cnt = 7'd0;
            d.pump_clk = 1'b0;
        end else if (edge_seen) begin
            // >= so a source change mid-count cannot overrun the new length
            if (q.cnt >= half - 7'd1) begin
                d.cnt = 7'd0;
                d.pump_clk = ~q.pump_clk;
            end else begin
                d.cnt = q.cnt + 7'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dv.pump_clk = q.pump_clk;

endmodule : apc_pump_div

// >>> verification/apc_analog_model.sv
// behavioural analog side: clock pins and low battery comparator
`timescale 1ns/1ps
module apc_analog_model (
    input wire logic bias_en,
    input wire logic lowbat_cmp_en,
    input wire logic [1:0] lowbat_input_sel,
    input wire logic [15:0] supply_mv,
    input wire logic [15:0] ain_mv,
    output logic main_clock,
    output logic external_osc_clock,
    output logic lowbat_result_async
);
    logic flt = 1'b0;
    // free running pins, slow against the sampling clock
    initial main_clock = 1'b0;
    initial external_osc_clock = 1'b0;
    always #16 main_clock = ~main_clock;
    always #24 external_osc_clock = ~external_osc_clock;
    // an unpowered or floating comparator wanders rather than sitting still
    always #7 flt = ~flt;
    always_comb begin
        if (!(lowbat_cmp_en && bias_en)) begin
            lowbat_result_async = flt;
        end else begin
            case (lowbat_input_sel)
                2'b00: lowbat_result_async = supply_mv > 16'd2300;
                2'b01: lowbat_result_async = supply_mv > 16'd3500;
                2'b10: lowbat_result_async = ain_mv > 16'd1200;
                default: lowbat_result_async = flt;
            endcase
        end
    end
endmodule : apc_analog_model

// >>> verification/apc_power_regs_assertions.sv
// bus, output level and reset checks of the power control bank
`timescale 1ns/1ps
module apc_power_regs_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_wdata,
    input wire logic [31:0] wb_rdata,
    input wire logic wb_ack,
    input wire logic supply_tap_en,
    input wire logic regulator_en,
    input wire logic bias_en,
    input wire logic common_voltage_en,
    input wire logic bandgap_en,
    input wire logic [1:0] lowbat_input_sel,
    input wire logic lowbat_route_half,
    input wire logic lowbat_route_third,
    input wire logic lowbat_route_ext,
    input wire logic analog_ready,
    input wire logic doubler_en,
    input wire logic doubler_clk,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    ack_pulse_a: assert property (wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("request not answered in one cycle");
    tap_write_a: assert property (wb_ack && wb_we && wb_sel[0] && wb_adr[7:2] == 6'h1c
        |=> supply_tap_en == $past(wb_wdata[4])) else $error("tap enable not written");
    aen_write_a: assert property (wb_ack && wb_we && wb_sel[0] && wb_adr[7:2] == 6'h1d
        |=> {bandgap_en, regulator_en, common_voltage_en, bias_en} ==
        {$past(wb_wdata[6]), $past(wb_wdata[5]), $past(wb_wdata[1]), $past(wb_wdata[0])})
        else $error("analog enables not written");
    route_decode_a: assert property ({lowbat_route_ext, lowbat_route_third, lowbat_route_half}
        == (lowbat_input_sel == 2'b11 ? 3'b000 : 3'b001 << lowbat_input_sel))
        else $error("comparator route decode wrong");
    ready_level_a: assert property (analog_ready == (regulator_en && bias_en))
        else $error("analog ready mismatch");
    doubler_idle_a: assert property (!doubler_en && !$past(doubler_en) |-> !doubler_clk)
        else $error("doubler clock runs while disabled");
    rdata_upper_a: assert property (wb_ack |-> wb_rdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    reset_zero_a: assert property ($rose(resetn) |-> !wb_ack && !irq && !doubler_en
        && !bias_en && !supply_tap_en) else $error("outputs not cleared by reset");
endmodule : apc_power_regs_assertions

bind apc_power_regs apc_power_regs_assertions u_chk (.clk(clk), .resetn(resetn),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_wdata(wb_wdata), .wb_rdata(wb_rdata), .wb_ack(wb_ack), .supply_tap_en(supply_tap_en),
    .regulator_en(regulator_en), .bias_en(bias_en), .common_voltage_en(common_voltage_en),
    .bandgap_en(bandgap_en), .lowbat_input_sel(lowbat_input_sel),
    .lowbat_route_half(lowbat_route_half), .lowbat_route_third(lowbat_route_third),
    .lowbat_route_ext(lowbat_route_ext), .analog_ready(analog_ready),
    .doubler_en(doubler_en), .doubler_clk(doubler_clk), .irq(irq));

// >>> verification/testbench.sv
// self-checking bench for the analog power control register bank
`timescale 1ns/1ps
module testbench;
    logic clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, main_clock, external_osc_clock;
    logic [7:0] wb_adr, rd, clock_select_out;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdata, wb_rdata;
    logic lowbat_result_async, main_clk_src_sel, doubler_en, doubler_rate_sel, doubler_clk;
    logic regulator_en, supply_tap_en, bias_en, common_voltage_en, bandgap_en, lowbat_cmp_en;
    logic [1:0] lowbat_input_sel;
    logic lowbat_route_half, lowbat_route_third, lowbat_route_ext, supply_above_2v3;
    logic supply_above_3v5, analog_ready, irq;
    logic [15:0] supply_mv, ain_mv;
    int num_errors, checks;

    apc_power_regs dut (.clk(clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
        .wb_rdata(wb_rdata), .wb_ack(wb_ack), .main_clock(main_clock),
        .external_osc_clock(external_osc_clock), .lowbat_result_async(lowbat_result_async),
        .clock_select_out(clock_select_out), .main_clk_src_sel(main_clk_src_sel),
        .doubler_en(doubler_en), .doubler_rate_sel(doubler_rate_sel), .doubler_clk(doubler_clk),
        .regulator_en(regulator_en), .supply_tap_en(supply_tap_en), .bias_en(bias_en),
        .common_voltage_en(common_voltage_en), .bandgap_en(bandgap_en),
        .lowbat_cmp_en(lowbat_cmp_en), .lowbat_input_sel(lowbat_input_sel),
        .lowbat_route_half(lowbat_route_half), .lowbat_route_third(lowbat_route_third),
        .lowbat_route_ext(lowbat_route_ext), .supply_above_2v3(supply_above_2v3),
        .supply_above_3v5(supply_above_3v5), .analog_ready(analog_ready), .irq(irq));

    apc_analog_model u_analog (.bias_en(bias_en), .lowbat_cmp_en(lowbat_cmp_en),
        .lowbat_input_sel(lowbat_input_sel), .supply_mv(supply_mv), .ain_mv(ain_mv),
        .main_clock(main_clock), .external_osc_clock(external_osc_clock),
        .lowbat_result_async(lowbat_result_async));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish;
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] sel);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= sel;
        wb_wdata <= {24'h000000, d};
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_rdata[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
        @(negedge clk);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 4'h1);
        chk_byte(rd, e);
    endtask : rdc

    task automatic t_reset;
        logic [7:0] a [6] = '{8'h50, 8'h54, 8'h70, 8'h74, 8'h80, 8'h88};
        foreach (a[i]) rdc(a[i], 8'h00);
        chk_bit(doubler_clk, 1'b0);
    endtask : t_reset

    task automatic t_regs;
        logic [7:0] a [4] = '{8'h50, 8'h54, 8'h70, 8'h74};
        logic [7:0] m [4] = '{8'hef, 8'h4f, 8'h1e, 8'h63};
        for (int i = 0; i < 4; i++) begin
            wr(a[i], 8'hff);
            wb(1'b1, a[i], 8'h00, 4'he);
            rdc(a[i], m[i]);
        end
        chk_bit(supply_tap_en, 1'b1);
        chk_bit(lowbat_cmp_en, 1'b1);
        chk_byte({bandgap_en, regulator_en, common_voltage_en, bias_en, 4'h0}, 8'hf0);
        chk_bit(doubler_en, 1'b1);
        chk_byte(clock_select_out, 8'hef);
        chk_bit(doubler_rate_sel, 1'b1);
        wr(8'h7c, 8'hff);
        rdc(8'h7c, 8'h00);
        rdc(8'h40, 8'h00);
        foreach (a[i]) wr(a[i], 8'h00);
        chk_bit(supply_tap_en, 1'b0);
        chk_bit(analog_ready, 1'b0);
    endtask : t_regs

    task automatic t_lowbat;
        wr(8'h54, 8'h40);
        wr(8'h74, 8'h20);
        wr(8'h74, 8'h21);
        wr(8'h88, 8'h01);
        wr(8'h84, 8'h03);
        wr(8'h70, 8'h02);
        repeat (8) @(posedge clk);
        rdc(8'h7c, 8'h01);
        chk_bit(supply_above_2v3, 1'b1);
        chk_bit(lowbat_route_half, 1'b1);
        chk_bit(irq, 1'b1);
        wr(8'h84, 8'h01);
        chk_bit(irq, 1'b0);
        wr(8'h70, 8'h06);
        repeat (8) @(posedge clk);
        rdc(8'h7c, 8'h00);
        rdc(8'h80, 8'h02);
        chk_bit(irq, 1'b0);
        chk_bit(lowbat_route_third, 1'b1);
        chk_byte({6'h00, lowbat_input_sel}, 8'h01);
        // fall event bit reaches the interrupt line once enabled
        wr(8'h88, 8'h02);
        chk_bit(irq, 1'b1);
        rdc(8'h88, 8'h02);
        wr(8'h84, 8'h02);
        chk_bit(irq, 1'b0);
        rdc(8'h80, 8'h00);
        wr(8'h88, 8'h01);
        supply_mv <= 16'd4000;
        repeat (8) @(posedge clk);
        chk_bit(supply_above_3v5, 1'b1);
        chk_bit(irq, 1'b1);
        ain_mv <= 16'd1300;
        wr(8'h70, 8'h0a);
        rdc(8'h7c, 8'h01);
        wr(8'h7c, 8'h00);
        rdc(8'h7c, 8'h01);
        chk_bit(lowbat_route_ext, 1'b1);
        wr(8'h70, 8'h08);
        repeat (8) @(posedge clk);
        rdc(8'h7c, 8'h00);
        wr(8'h88, 8'h00);
        chk_bit(irq, 1'b0);
    endtask : t_lowbat

    task automatic t_pump;
        logic [7:0] ck [3] = '{8'h00, 8'h00, 8'h01};
        logic [7:0] pk [3] = '{8'h40, 8'h41, 8'h40};
        realtime per [3] = '{6400.0, 3200.0, 1536.0};
        realtime t1;
        for (int i = 0; i < 3; i++) begin
            wr(8'h50, ck[i]);
            wr(8'h54, pk[i]);
            repeat (2) @(posedge doubler_clk);
            t1 = $realtime;
            @(posedge doubler_clk);
            t1 = $realtime - t1;
            chk_bit(t1 > per[i] - 9.0 && t1 < per[i] + 9.0, 1'b1);
        end
        chk_bit(main_clk_src_sel, 1'b1);
    endtask : t_pump

    initial begin
        #200us;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        resetn = 1'b0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdata} = '0;
        supply_mv = 16'd3000;
        ain_mv = 16'd1000;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_lowbat();
        t_pump();
        tally_and_finish();
    end
endmodule : testbench
